// File: core/scd_consts.svh
// named constants of the spi command decoder: opcodes, pointers, fields
// assumes inclusion by bare name from each design file that needs them
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH

// ************************************************************
// command opcodes
// ************************************************************
`define SCD_OP_RESET   8'hc0
`define SCD_OP_READ    8'h03
`define SCD_OP_WRITE   8'h02
`define SCD_OP_BITMOD  8'h05
`define SCD_OP_RDSTAT  8'ha0
`define SCD_OP_RXSTAT  8'hb0
`define SCD_QRD_MASK   8'hf9
`define SCD_QRD_CODE   8'h90
`define SCD_SEL3_MASK  8'hf8
`define SCD_LTX_CODE   8'h40
`define SCD_RTS_CODE   8'h80

// ************************************************************
// opcode select fields
// ************************************************************
`define SCD_SEL_MSB    2
`define SCD_SEL_LSB    0
`define SCD_QRD_N      2
`define SCD_QRD_M      1
`define SCD_LTX_C      0

// ************************************************************
// buffer pointers
// ************************************************************
`define SCD_RECEIVE_BUFFER_ZERO       8'h60
`define SCD_RECEIVE_BUFFER_ONE       8'h70
`define SCD_TRANSMIT_BUFFER_ZERO       8'h30
`define SCD_TRANSMIT_BUFFER_ONE       8'h40
`define SCD_TXB2       8'h50
`define SCD_ID_OFS     8'h01
`define SCD_DATA_OFS   8'h06
`define SCD_TX_NONE    2'h3

// ************************************************************
// misc values
// ************************************************************
`define SCD_FULL_MASK  8'hff
`define SCD_BIT_FIRST  3'h0
`define SCD_BIT_LAST   3'h7
`define SCD_PIN_RST    3'h4
`define SCD_CLR_BUF0   2'h1
`define SCD_CLR_BUF1   2'h2

`endif

// File: core/scd_decoder.sv
// spi command decoder: takes serial commands, drives register strobes
// assumes a register file that answers REG_RDATA for REG_ADDR at once
`timescale 1ns/10ps
`include "scd_consts.svh"

// Summary of operation
// - reset opcode pulses register reset, config
// - read opcode, address, then data streams out
// - write opcode, address, then bytes stored
// - quick read points at receive buffer
// - chip select rise clears read buffer flag
// - quick load points at transmit buffer
// - transmit request sets selected buffer flags
// - request with no buffers selected ignored
// - status poll returns one status byte
// - status poll repeats while clocked
// - receive status byte repeats while selected
// - bits 7:6 mirror receive-full flags
// - bit 4 extended, bit 3 remote
// - bits 2:0 name matching filter
// - buffer zero describes low bits first
// - bit modify changes masked register bits
// - unsupported register forces full mask
// - first byte after select is opcode
// - sample on rise, shift on fall
// - pointer advances after each read byte
module scd_decoder (
  // clock, reset and enable
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic       CE,
  // serial pins
  input  wire logic       CS_N,
  input  wire logic       SCK,
  input  wire logic       SI,
  output logic            SO,
  output logic            SO_OE_N,
  // register file port
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  output logic            REG_WE,
  output logic            REG_RE,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_BITMOD_OK,
  // control strobes
  output logic            SOFT_RESET,
  output logic      [2:0] TX_REQ,
  output logic      [1:0] RX_FULL_CLR,
  // status sources
  input  wire logic [7:0] STATUS_BYTE,
  input  wire logic [1:0] RX_FULL,
  input  wire logic       RX0_EXT,
  input  wire logic       RX0_RTR,
  input  wire logic [2:0] RX0_FILT,
  input  wire logic       RX1_EXT,
  input  wire logic       RX1_RTR,
  input  wire logic [2:0] RX1_FILT
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [2:0]            pin_s;      // synced cs_n, sck, si
  logic                  csn_s;      // synced chip select, low active
  logic                  sck_s;      // synced serial clock
  logic                  si_s;       // synced serial data in
  logic                  sck_d_ff;   // sck one cycle late
  logic                  csn_d_ff;   // cs_n one cycle late
  logic                  sck_rise;   // rising sck inside a frame
  logic                  sck_fall;   // falling sck inside a frame
  logic                  cs_rise;    // end of a frame
  logic                  byte_done;  // eighth bit sampled
  logic                  at_opc;     // opcode byte complete
  logic [2:0]            bitcnt_ff;  // bit position in byte
  logic [7:0]            rx_sh_ff;   // incoming shift register
  logic [7:0]            cur_byte;   // byte including current bit
  logic [7:0]            tx_sh_ff;   // outgoing shift register
  logic [7:0]            addr_ff;    // register pointer
  logic [7:0]            wdata_ff;   // write data
  logic [7:0]            mask_ff;    // bit modify mask
  logic [7:0]            eff_mask;   // mask after support check
  logic [7:0]            rxs_hold_ff; // frozen receive status
  logic [7:0]            rx_stat;    // live receive status
  logic [7:0]            qptr;       // quick pointer target
  logic [1:0]            tx_sel;     // transmit buffer pick
  logic                  is_qrd;     // quick receive read opcode
  logic                  is_ltx;     // valid quick load opcode
  logic                  is_rts;     // transmit request opcode
  logic                  we_ff;      // write strobe
  logic                  re_ff;      // read strobe
  logic                  so_ff;      // serial out bit
  logic                  so_oe_n_ff; // serial out enable
  logic                  soft_ff;    // register reset strobe
  logic [2:0]            transmit_request_flag_ff;   // transmit request strobes
  logic [1:0]            rxclr_ff;   // receive-full clear strobes
  logic                  qrd_ff;     // frame was a quick read
  logic                  qbuf_ff;    // buffer used by quick read
  scd_pkg::scd_state_e   state_ff;   // frame phase

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  // the link clock is just a sampled pin; 100 mhz vs 12.5 mhz sck
  scd_sync #(
    .W   (3),
    .RST (`SCD_PIN_RST)
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .ce   (CE),
    .din  ({CS_N, SCK, SI}),
    .dout (pin_s)
  );

  assign csn_s = pin_s[2];
  assign sck_s = pin_s[1];
  assign si_s  = pin_s[0];

  // delayed copies for edge detection
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sck_d_ff <= 1'b0;
      csn_d_ff <= 1'b1;
    end else if (CE) begin
      sck_d_ff <= sck_s;
      csn_d_ff <= csn_s;
    end
  end

  // rise samples, fall shifts
  // either idle level works: edges count only inside a frame
  assign sck_rise  = sck_s & ~sck_d_ff & ~csn_s;
  assign sck_fall  = ~sck_s & sck_d_ff & ~csn_s;
  assign cs_rise   = csn_s & ~csn_d_ff;
  assign cur_byte  = {rx_sh_ff[6:0], si_s};
  assign byte_done = sck_rise & (bitcnt_ff == `SCD_BIT_LAST);
  assign at_opc    = byte_done & (state_ff == scd_pkg::S_OPC);

  // ************************************************************
  // opcode decode
  // ************************************************************
  assign is_qrd = (cur_byte & `SCD_QRD_MASK) == `SCD_QRD_CODE;
  assign is_rts = (cur_byte & `SCD_SEL3_MASK) == `SCD_RTS_CODE;
  assign tx_sel = cur_byte[`SCD_QRD_N:`SCD_QRD_M];
  // select codes past the third buffer name nothing and are ignored
  assign is_ltx = ((cur_byte & `SCD_SEL3_MASK) == `SCD_LTX_CODE) &&
                  (tx_sel != `SCD_TX_NONE);

  // quick pointer for receive and transmit buffer opcodes
  always_comb begin
    qptr = `SCD_RECEIVE_BUFFER_ZERO;
    if (is_qrd) begin
      qptr = cur_byte[`SCD_QRD_N] ? `SCD_RECEIVE_BUFFER_ONE : `SCD_RECEIVE_BUFFER_ZERO;
      qptr = qptr + (cur_byte[`SCD_QRD_M] ? `SCD_DATA_OFS : `SCD_ID_OFS);
    end else begin
      case (tx_sel)
        2'h0:    qptr = `SCD_TRANSMIT_BUFFER_ZERO;
        2'h1:    qptr = `SCD_TRANSMIT_BUFFER_ONE;
        default: qptr = `SCD_TXB2;
      endcase
      qptr = qptr + (cur_byte[`SCD_LTX_C] ? `SCD_DATA_OFS : `SCD_ID_OFS);
    end
  end

  // ************************************************************
  // frame phase
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_ff <= scd_pkg::S_OPC;
    end else if (CE) begin
      if (csn_s) begin
        state_ff <= scd_pkg::S_OPC;
      end else if (byte_done) begin
        case (state_ff)
          scd_pkg::S_OPC: begin
            if (cur_byte == `SCD_OP_READ) begin
              state_ff <= scd_pkg::S_RADDR;
            end else if (cur_byte == `SCD_OP_WRITE) begin
              state_ff <= scd_pkg::S_WADDR;
            end else if (cur_byte == `SCD_OP_BITMOD) begin
              state_ff <= scd_pkg::S_BADDR;
            end else if (cur_byte == `SCD_OP_RDSTAT) begin
              state_ff <= scd_pkg::S_STAT;
            end else if (cur_byte == `SCD_OP_RXSTAT) begin
              state_ff <= scd_pkg::S_RXST;
            end else if (is_qrd) begin
              state_ff <= scd_pkg::S_RD;
            end else if (is_ltx) begin
              state_ff <= scd_pkg::S_WR;
            end else begin
              // reset, request and unknown opcodes take no more bytes
              state_ff <= scd_pkg::S_IGN;
            end
          end
          scd_pkg::S_RADDR: state_ff <= scd_pkg::S_RD;
          scd_pkg::S_WADDR: state_ff <= scd_pkg::S_WR;
          scd_pkg::S_BADDR: state_ff <= scd_pkg::S_BMASK;
          scd_pkg::S_BMASK: state_ff <= scd_pkg::S_BDATA;
          scd_pkg::S_BDATA: state_ff <= scd_pkg::S_IGN;
          default:          state_ff <= state_ff;
        endcase
      end
    end
  end

  // ************************************************************
  // serial input shifter
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      bitcnt_ff <= `SCD_BIT_FIRST;
      rx_sh_ff  <= 8'h00;
    end else if (CE) begin
      if (csn_s) begin
        bitcnt_ff <= `SCD_BIT_FIRST;
      end else if (sck_rise) begin
        bitcnt_ff <= bitcnt_ff + 3'h1;
        rx_sh_ff  <= cur_byte;
      end
    end
  end

  // ************************************************************
  // register pointer
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      addr_ff <= 8'h00;
    end else if (CE) begin
      if (at_opc && (is_qrd || is_ltx)) begin
        addr_ff <= qptr;
      end else if (byte_done && (state_ff == scd_pkg::S_RADDR ||
                                 state_ff == scd_pkg::S_WADDR ||
                                 state_ff == scd_pkg::S_BADDR)) begin
        addr_ff <= cur_byte;
      end else if (re_ff || (we_ff && state_ff == scd_pkg::S_WR)) begin
        addr_ff <= addr_ff + 8'h01;
      end
    end
  end

  // ************************************************************
  // register strobes and write data
  // ************************************************************
  // full mask when unsupported
  assign eff_mask = REG_BITMOD_OK ? mask_ff : `SCD_FULL_MASK;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      we_ff    <= 1'b0;
      re_ff    <= 1'b0;
      wdata_ff <= 8'h00;
      mask_ff  <= 8'h00;
    end else if (CE) begin
      // fetch one cycle after the byte that asks for data
      re_ff <= byte_done && (state_ff == scd_pkg::S_RADDR ||
                             state_ff == scd_pkg::S_RD ||
                             (state_ff == scd_pkg::S_OPC && is_qrd));
      we_ff <= 1'b0;
      if (byte_done && state_ff == scd_pkg::S_BMASK) begin
        mask_ff <= cur_byte;
      end
      if (byte_done && state_ff == scd_pkg::S_WR) begin
        we_ff    <= 1'b1;
        wdata_ff <= cur_byte;
      end else if (byte_done && state_ff == scd_pkg::S_BDATA) begin
        we_ff    <= 1'b1;
        wdata_ff <= (REG_RDATA & ~eff_mask) | (cur_byte & eff_mask);
      end
    end
  end

  // ************************************************************
  // serial output path
  // ************************************************************
  scd_rxstat u_rxstat (
    .full  (RX_FULL),
    .ext0  (RX0_EXT),
    .rtr0  (RX0_RTR),
    .filt0 (RX0_FILT),
    .ext1  (RX1_EXT),
    .rtr1  (RX1_RTR),
    .filt1 (RX1_FILT),
    .stat  (rx_stat)
  );

  // loads never meet a fall: a fall trails its rise by several cycles
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tx_sh_ff    <= 8'h00;
      rxs_hold_ff <= 8'h00;
    end else if (CE) begin
      if (csn_s) begin
        tx_sh_ff <= 8'h00;
      end else if (re_ff) begin
        tx_sh_ff <= REG_RDATA;
      end else if (byte_done && (state_ff == scd_pkg::S_STAT ||
                   (state_ff == scd_pkg::S_OPC && cur_byte == `SCD_OP_RDSTAT))) begin
        tx_sh_ff <= STATUS_BYTE;
      end else if (at_opc && cur_byte == `SCD_OP_RXSTAT) begin
        tx_sh_ff    <= rx_stat;
        rxs_hold_ff <= rx_stat;
      end else if (byte_done && state_ff == scd_pkg::S_RXST) begin
        tx_sh_ff <= rxs_hold_ff;
      end else if (sck_fall) begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end

  // inside a frame the output bit changes on the falling edge only
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      so_ff      <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end else if (CE) begin
      so_oe_n_ff <= csn_s;
      if (csn_s) begin
        so_ff <= 1'b0;
      end else if (sck_fall) begin
        so_ff <= tx_sh_ff[7];
      end
    end
  end

  // ************************************************************
  // control strobes
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      soft_ff  <= 1'b0;
      transmit_request_flag_ff <= 3'h0;
      rxclr_ff <= 2'h0;
      qrd_ff   <= 1'b0;
      qbuf_ff  <= 1'b0;
    end else if (CE) begin
      soft_ff  <= at_opc && (cur_byte == `SCD_OP_RESET);
      transmit_request_flag_ff <= (at_opc && is_rts) ? cur_byte[`SCD_SEL_MSB:`SCD_SEL_LSB] : 3'h0;
      rxclr_ff <= 2'h0;
      if (cs_rise && qrd_ff) begin
        rxclr_ff <= qbuf_ff ? `SCD_CLR_BUF1 : `SCD_CLR_BUF0;
      end
      if (cs_rise) begin
        qrd_ff <= 1'b0;
      end else if (at_opc && is_qrd) begin
        qrd_ff  <= 1'b1;
        qbuf_ff <= cur_byte[`SCD_QRD_N];
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign SO          = so_ff;
  assign SO_OE_N     = so_oe_n_ff;
  assign REG_ADDR    = addr_ff;
  assign REG_WDATA   = wdata_ff;
  assign REG_WE      = we_ff;
  assign REG_RE      = re_ff;
  assign SOFT_RESET  = soft_ff;
  assign TX_REQ      = transmit_request_flag_ff;
  assign RX_FULL_CLR = rxclr_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_opcode(logic [7:0] op);
    CE && at_opc && cur_byte == op;
  endsequence

  sequence s_cmd_byte(scd_pkg::scd_state_e st);
    CE && byte_done && state_ff == st;
  endsequence

  a_reset_strobe: assert property (
    s_opcode(`SCD_OP_RESET) |=> SOFT_RESET ##1 (!SOFT_RESET || !CE))
    else $error("reset opcode gave no single strobe");
  a_read_fetch: assert property (
    s_cmd_byte(scd_pkg::S_RADDR) |=> REG_RE && REG_ADDR == $past(cur_byte))
    else $error("read address not fetched");
  a_write_store: assert property (
    s_cmd_byte(scd_pkg::S_WR) |=> REG_WE && REG_WDATA == $past(cur_byte))
    else $error("write byte not stored");
  a_quick_ptr: assert property (
    (CE && at_opc && is_qrd) |=> REG_RE && REG_ADDR == $past(qptr))
    else $error("quick read pointer wrong");
  a_rx_clear: assert property (
    (CE && cs_rise && qrd_ff) |=> RX_FULL_CLR != 2'h0)
    else $error("receive flag not cleared");
  a_rts_none: assert property (
    (CE && at_opc && is_rts && cur_byte[`SCD_SEL_MSB:`SCD_SEL_LSB] == 3'h0) |=> TX_REQ == 3'h0)
    else $error("empty request acted");
  a_rts_sel: assert property (
    (CE && at_opc && is_rts) |=> TX_REQ == $past(cur_byte[`SCD_SEL_MSB:`SCD_SEL_LSB]))
    else $error("request strobes wrong");
  a_ptr_step: assert property (
    (CE && REG_RE) |=> REG_ADDR == $past(REG_ADDR) + 8'h01)
    else $error("pointer did not advance");
  a_abort_cs: assert property (
    (CE && csn_s) |=> state_ff == scd_pkg::S_OPC && bitcnt_ff == `SCD_BIT_FIRST)
    else $error("deselect did not abort");
  a_so_hold: assert property (
    (CE && !csn_s && !sck_fall) |=> $stable(so_ff))
    else $error("output changed off falling edge");
  a_rxs_repeat: assert property (
    s_cmd_byte(scd_pkg::S_RXST) |=> tx_sh_ff == rxs_hold_ff)
    else $error("receive status not repeated");

endmodule

// File: core/scd_pkg.sv
// types shared by the spi command decoder files
// assumes nothing of its surroundings
package scd_pkg;

  // decoder phase within one chip-select frame
  typedef enum logic [3:0] {
    S_OPC,
    S_RADDR,
    S_WADDR,
    S_BADDR,
    S_BMASK,
    S_BDATA,
    S_RD,
    S_WR,
    S_STAT,
    S_RXST,
    S_IGN
  } scd_state_e;

endpackage

// File: core/scd_rxstat.sv
// builds the receive-status byte from the two receive buffers
// assumes flag and frame-type inputs are stable levels on one clock
`timescale 1ns/10ps

module scd_rxstat (
  // receive-full flags, buffer one in bit 1
  input  wire logic [1:0] full,
  // buffer zero frame description
  input  wire logic       ext0,
  input  wire logic       rtr0,
  input  wire logic [2:0] filt0,
  // buffer one frame description
  input  wire logic       ext1,
  input  wire logic       rtr1,
  input  wire logic [2:0] filt1,
  // assembled status byte
  output logic      [7:0] stat
);

  // ************************************************************
  // status byte assembly
  // ************************************************************
  // buffer zero wins when both hold a message; unused bit reads zero
  always_comb begin
    stat = {full, 6'h00};
    if (full[0]) begin
      stat = {full, 1'b0, ext0, rtr0, filt0};
    end else if (full[1]) begin
      stat = {full, 1'b0, ext1, rtr1, filt1};
    end
  end

endmodule

// File: core/scd_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to clk and change slowly
`timescale 1ns/10ps

module scd_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock, reset and enable
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // first stage, read only by the second stage
  logic [W-1:0] meta_ff;

  // ************************************************************
  // two flip-flop stages
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= RST;
      dout    <= RST;
    end else if (ce) begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule

// File: tb/scd_host.sv
// host model: spi master driving the decoder pins, modes 0,0 and 1,1
// assumes clk is the 100 MHz system clock; pins move on its falling edge
`timescale 1ns/10ps

module scd_host (
  // system clock
  input  wire logic clk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so
);
  logic cpol; // idle level of sck, high for mode 1,1

  initial begin
    cpol = 1'b0;
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // half an sck period: 4 clocks, 80 ns per bit
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  task automatic sel();
    sck = cpol;
    half();
    cs_n = 1'b0;
    half();
  endtask

  // sck parks at idle before select rises; si is left toggled
  task automatic desel();
    half();
    sck = cpol;
    half();
    cs_n = 1'b1;
    si   = ~si;
    half();
  endtask

  // si set after the fall, so taken on the rise, msb first
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int b = 0; b < n; b++) begin
      sck = 1'b0;
      si  = tx[7-b];
      half();
      rx  = {rx[6:0], so};
      sck = 1'b1;
      half();
    end
  endtask
endmodule

// File: tb/tb_scd_decoder.sv
// self-checking bench of the spi command decoder, random with corners
// assumes scd_host as spi master and a register file modelled here
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end

module tb_scd_decoder;
  logic       CLK = 1'b0, NRST, CE = 1'b1, SO, SO_OE_N, REG_WE, REG_RE, SOFT_RESET;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, STATUS_BYTE, a, d, m, r, sb;
  logic [2:0] TX_REQ, RX0_FILT, RX1_FILT, txr;
  logic [1:0] RX_FULL_CLR, RX_FULL, clr;
  logic       RX0_EXT, RX0_RTR, RX1_EXT, RX1_RTR, REG_BITMOD_OK;
  wire        CS_N, SCK, SI;
  int         err_total = 0, n_checks = 0, we_n, rst_n, seed = 91985;
  logic [7:0] wa, wd;

  always #5 CLK = ~CLK;
  // register file: content derived from address, odd addresses bit-modifiable
  assign REG_RDATA     = REG_ADDR ^ 8'h5a;
  assign REG_BITMOD_OK = REG_ADDR[0];

  // a released so line has no pull: the host sees the inverse of SO, which is cleared to zero, so a one
  scd_host h (.clk(CLK), .cs_n(CS_N), .sck(SCK), .si(SI), .so(SO_OE_N ? ~SO : SO));
  scd_decoder dut (.CLK(CLK), .NRST(NRST), .CE(CE), .CS_N(CS_N), .SCK(SCK), .SI(SI),
    .SO(SO), .SO_OE_N(SO_OE_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
    .REG_BITMOD_OK(REG_BITMOD_OK), .SOFT_RESET(SOFT_RESET), .TX_REQ(TX_REQ),
    .RX_FULL_CLR(RX_FULL_CLR), .STATUS_BYTE(STATUS_BYTE), .RX_FULL(RX_FULL),
    .RX0_EXT(RX0_EXT), .RX0_RTR(RX0_RTR), .RX0_FILT(RX0_FILT), .RX1_EXT(RX1_EXT),
    .RX1_RTR(RX1_RTR), .RX1_FILT(RX1_FILT));

  // strobe monitor: pulses are gathered so one frame can be judged after it ends
  always @(posedge CLK) begin
    if (REG_WE) begin
      we_n++;
      wa = REG_ADDR;
      wd = REG_WDATA;
    end
    rst_n += int'(SOFT_RESET);
    txr |= TX_REQ;
    clr |= RX_FULL_CLR;
  end

  function automatic logic [7:0] mem(input logic [7:0] x);
    return x ^ 8'h5a;
  endfunction

  // buffer zero wins the low bits when both are full
  function automatic logic [7:0] rxs();
    if (RX_FULL[0]) return {RX_FULL, 1'b0, RX0_EXT, RX0_RTR, RX0_FILT};
    if (RX_FULL[1]) return {RX_FULL, 1'b0, RX1_EXT, RX1_RTR, RX1_FILT};
    return {RX_FULL, 6'h00};
  endfunction

  task automatic go(input logic [7:0] op);
    @(negedge CLK);
    // idle freeze: the enable drops between frames, nothing may move
    CE = 1'b0;
    repeat (2) @(negedge CLK);
    CE = 1'b1;
    we_n = 0; rst_n = 0; txr = 3'h0; clr = 2'h0;
    h.sel();
    h.xfer(op, 8, r);
  endtask

  // let the synced select rise and its strobes land
  task automatic stop();
    h.desel();
    repeat (10) @(negedge CLK);
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (50000) @(negedge CLK);
    err_total++;
    close_out();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    NRST = 1'b0; STATUS_BYTE = 8'h00; RX_FULL = 2'h0;
    {RX0_EXT, RX0_RTR, RX0_FILT, RX1_EXT, RX1_RTR, RX1_FILT} = 10'h000;
    repeat (6) @(negedge CLK);
    NRST = 1'b1;
    repeat (4) @(negedge CLK);
    go(8'hc0); stop(); `CHK(rst_n, 1)
    for (int i = 0; i < 2; i++) begin
      h.cpol = i[0]; a = $random(seed);
      go(8'h03); h.xfer(a, 8, r);
      `CHK(SO_OE_N, 1'b0)
      h.xfer(8'h00, 8, r);
      `CHK(r, mem(a))
      h.xfer(8'h00, 8, r); stop();
      `CHK(r, mem(a + 8'h01))
      `CHK(SO_OE_N, 1'b1)
    end
    h.cpol = 1'b0; a = $random(seed); d = $random(seed);
    go(8'h02); h.xfer(a, 8, r); h.xfer(d, 8, r); h.xfer(~d, 8, r); h.xfer(d, 4, r); stop();
    `CHK(wa, a + 8'h01)
    `CHK(wd, ~d)
    `CHK(we_n, 2)
    for (int i = 0; i < 4; i++) begin
      go(8'h90 | 8'(i << 1)); h.xfer(8'h00, 8, r); stop();
      `CHK(r, mem((i[1] ? 8'h70 : 8'h60) + (i[0] ? 8'h06 : 8'h01)))
      `CHK(clr, 2'(1 << i[1]))
    end
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      go(8'h40 | 8'(i)); h.xfer(d, 8, r); stop();
      `CHK(wa, 8'(8'h30 + 16 * (i / 2) + ((i % 2) ? 6 : 1)))
      `CHK(wd, d)
    end
    for (int i = 0; i < 8; i++) begin
      go(8'h80 | 8'(i)); stop();
      `CHK(txr, 3'(i))
    end
    sb = $random(seed); STATUS_BYTE = sb;
    go(8'ha0); h.xfer(8'h00, 8, r);
    `CHK(r, sb)
    h.xfer(8'h00, 8, r); stop();
    `CHK(r, sb)
    for (int f = 0; f < 4; f++) begin
      {RX0_EXT, RX0_RTR, RX0_FILT, RX1_EXT, RX1_RTR, RX1_FILT} = 10'($random(seed));
      RX_FULL = 2'(f);
      go(8'hb0); h.xfer(8'h00, 8, r);
      `CHK(r, rxs())
      h.xfer(8'h00, 8, r); stop();
      `CHK(r, rxs())
    end
    for (int i = 0; i < 2; i++) begin
      a = {7'($random(seed)), i[0]}; m = $random(seed); d = $random(seed);
      go(8'h05); h.xfer(a, 8, r); h.xfer(m, 8, r); h.xfer(d, 8, r); stop();
      `CHK(wa, a)
      `CHK(wd, i[0] ? ((mem(a) & ~m) | (d & m)) : d)
    end
    close_out();
  end
endmodule
